// *** rtl/lane_steer_pkg.sv ***
// Package of constants and carrier types for the external data lane steering block.
package lane_steer_pkg;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] PORT_DIR_RST = 8'h00;
    localparam logic [7:0] PORT_OUT_RST = 8'h00;
    localparam logic [15:0] DATA_RST = 16'h0000;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic write;
        logic external;
        logic muxed;
        logic strobe_n;
        logic addr_odd;
        logic [7:0] low_addr;
        logic [15:0] wdata;
    } cycle_s;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } pin_drive_s;

    typedef struct packed {
        logic [7:0] low_sync1;
        logic [7:0] low_sync2;
        logic [7:0] high_sync1;
        logic [7:0] high_sync2;
        logic width8_sync1;
        logic width8_sync2;
        pin_drive_s low_port;
        pin_drive_s high_port;
        logic [15:0] rdata;
        logic rvalid;
        logic [7:0] gpio_low_in;
        logic [7:0] gpio_high_in;
    } steer_state_s;

endpackage : lane_steer_pkg

// *** rtl/lane_steer.sv ***
// Data lane steering between the internal 16-bit bus and the two external data ports.
`timescale 1ns/1ps
module lane_steer (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic expansion_mode,
    input wire logic bus_width8_pin,
    input wire lane_steer_pkg::cycle_s cyc,
    input wire lane_steer_pkg::pin_drive_s gpio_low,
    input wire lane_steer_pkg::pin_drive_s gpio_high,
    input wire logic [7:0] low_data_port_in,
    input wire logic [7:0] high_data_port_in,
    output logic [7:0] low_data_port_out,
    output logic [7:0] low_data_port_oe,
    output logic [7:0] high_data_port_out,
    output logic [7:0] high_data_port_oe,
    output logic [15:0] rdata,
    output logic rvalid,
    output logic [7:0] gpio_low_in,
    output logic [7:0] gpio_high_in
);

    lane_steer_pkg::steer_state_s st;
    lane_steer_pkg::steer_state_s next_st;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic w8;
        logic [7:0] lo_pins;
        logic [7:0] hi_pins;
        w8 = st.width8_sync2;
        lo_pins = st.low_sync2;
        hi_pins = st.high_sync2;
        next_st = st;
        next_st.low_sync1 = low_data_port_in;
        next_st.low_sync2 = st.low_sync1;
        next_st.high_sync1 = high_data_port_in;
        next_st.high_sync2 = st.high_sync1;
        next_st.width8_sync1 = bus_width8_pin;
        next_st.width8_sync2 = st.width8_sync1;
        next_st.gpio_low_in = lo_pins;
        next_st.gpio_high_in = hi_pins;
        next_st.rvalid = 1'b0;
        next_st.low_port = gpio_low;
        next_st.high_port = gpio_high;
        if (expansion_mode) begin
            next_st.low_port = '{out: 8'h00, oe: 8'h00};
            if (w8) begin
                next_st.high_port = gpio_high;
            end else begin
                next_st.high_port = '{out: 8'h00, oe: 8'h00};
            end
            if (cyc.valid && cyc.write) begin
                if (!w8) begin
                    next_st.low_port = '{out: cyc.wdata[7:0], oe: 8'hFF};
                    next_st.high_port = '{out: cyc.wdata[15:8], oe: 8'hFF};
                end else if (cyc.external && cyc.muxed && cyc.strobe_n) begin
                    next_st.low_port = '{out: cyc.low_addr, oe: 8'hFF};
                end else begin
                    next_st.low_port = '{out: cyc.addr_odd ? cyc.wdata[15:8] : cyc.wdata[7:0], oe: 8'hFF};
                end
            end else if (cyc.valid && cyc.external) begin
                if (w8 && cyc.muxed && cyc.strobe_n) begin
                    next_st.low_port = '{out: cyc.low_addr, oe: 8'hFF};
                end else begin
                    next_st.rvalid = 1'b1;
                    next_st.rdata = st.rdata;
                    if (!w8) begin
                        next_st.rdata[7:0] = lo_pins;
                        if (cyc.addr_odd) begin
                            next_st.rdata[15:8] = hi_pins;
                        end
                    end else if (cyc.addr_odd) begin
                        next_st.rdata[15:8] = lo_pins;
                    end else begin
                        next_st.rdata[7:0] = lo_pins;
                    end
                end
            end
            // Internal reads leave both ports undriven in 16-bit mode.
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            st <= '0;
            st.low_port <= '{out: lane_steer_pkg::PORT_OUT_RST, oe: lane_steer_pkg::PORT_DIR_RST};
            st.high_port <= '{out: lane_steer_pkg::PORT_OUT_RST, oe: lane_steer_pkg::PORT_DIR_RST};
            st.rdata <= lane_steer_pkg::DATA_RST;
        end else begin
            st <= next_st;
        end
    end

    assign low_data_port_out = st.low_port.out;
    assign low_data_port_oe = st.low_port.oe;
    assign high_data_port_out = st.high_port.out;
    assign high_data_port_oe = st.high_port.oe;
    assign rdata = st.rdata;
    assign rvalid = st.rvalid;
    assign gpio_low_in = st.gpio_low_in;
    assign gpio_high_in = st.gpio_high_in;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_single_chip;
        @(posedge clk_sys) disable iff (!rstn)
        !expansion_mode ##1 rstn |-> low_data_port_oe == $past(gpio_low.oe);
    endproperty
    a_single_chip: assert property (p_single_chip) else $error("Low port direction not from port control.");

    property p_ext_read16;
        @(posedge clk_sys) disable iff (!rstn)
        expansion_mode && cyc.valid && !cyc.write && cyc.external && !st.width8_sync2
            |=> rvalid && rdata[7:0] == $past(st.low_sync2);
    endproperty
    a_ext_read16: assert property (p_ext_read16) else $error("16-bit read low lane wrong.");

    property p_int_read;
        @(posedge clk_sys) disable iff (!rstn)
        expansion_mode && cyc.valid && !cyc.write && !cyc.external && !st.width8_sync2
            |=> low_data_port_oe == 8'h00 && high_data_port_oe == 8'h00;
    endproperty
    a_int_read: assert property (p_int_read) else $error("Data pins driven on internal read.");

    property p_write16;
        @(posedge clk_sys) disable iff (!rstn)
        expansion_mode && cyc.valid && cyc.write && !st.width8_sync2
            |=> low_data_port_out == $past(cyc.wdata[7:0]) && high_data_port_out == $past(cyc.wdata[15:8]);
    endproperty
    a_write16: assert property (p_write16) else $error("16-bit write lanes wrong.");

    property p_write_oe;
        @(posedge clk_sys) disable iff (!rstn)
        expansion_mode && cyc.valid && cyc.write |=> low_data_port_oe == 8'hFF;
    endproperty
    a_write_oe: assert property (p_write_oe) else $error("Write not driving low port.");

    property p_write8;
        @(posedge clk_sys) disable iff (!rstn)
        expansion_mode && cyc.valid && cyc.write && st.width8_sync2 && !cyc.muxed && cyc.addr_odd
            |=> low_data_port_out == $past(cyc.wdata[15:8]);
    endproperty
    a_write8: assert property (p_write8) else $error("8-bit odd write lane wrong.");

    property p_muxed_addr;
        @(posedge clk_sys) disable iff (!rstn)
        expansion_mode && cyc.valid && cyc.external && st.width8_sync2 && cyc.muxed && cyc.strobe_n
            |=> low_data_port_out == $past(cyc.low_addr) && !rvalid;
    endproperty
    a_muxed_addr: assert property (p_muxed_addr) else $error("Muxed address phase wrong.");

    property p_read8_odd;
        @(posedge clk_sys) disable iff (!rstn)
        expansion_mode && cyc.valid && !cyc.write && cyc.external && st.width8_sync2 && !cyc.muxed && cyc.addr_odd
            |=> rvalid && rdata[15:8] == $past(st.low_sync2) && rdata[7:0] == $past(rdata[7:0]);
    endproperty
    a_read8_odd: assert property (p_read8_odd) else $error("8-bit odd read lane wrong.");

    property p_high_gpio;
        @(posedge clk_sys) disable iff (!rstn)
        expansion_mode && st.width8_sync2 |=> high_data_port_oe == $past(gpio_high.oe);
    endproperty
    a_high_gpio: assert property (p_high_gpio) else $error("High port not general I/O in 8-bit mode.");

    // ------------------------------------------------------------
    // Further lane checks
    // ------------------------------------------------------------

    property p_write16_oe;
        @(posedge clk_sys) disable iff (!rstn)
        expansion_mode && cyc.valid && cyc.write && !st.width8_sync2
            |=> low_data_port_oe == 8'hFF && high_data_port_oe == 8'hFF;
    endproperty
    a_write16_oe: assert property (p_write16_oe) else $error("16-bit write not driving both ports.");

    property p_read16_high_odd;
        @(posedge clk_sys) disable iff (!rstn)
        expansion_mode && cyc.valid && !cyc.write && cyc.external && !st.width8_sync2 && cyc.addr_odd
            |=> rdata[15:8] == $past(st.high_sync2);
    endproperty
    a_read16_high_odd: assert property (p_read16_high_odd) else $error("16-bit odd read high lane wrong.");

    property p_read16_high_even;
        @(posedge clk_sys) disable iff (!rstn)
        expansion_mode && cyc.valid && !cyc.write && cyc.external && !st.width8_sync2 && !cyc.addr_odd
            |=> rdata[15:8] == $past(rdata[15:8]);
    endproperty
    a_read16_high_even: assert property (p_read16_high_even) else $error("16-bit even read changed high lane.");

    property p_read16_hiz;
        @(posedge clk_sys) disable iff (!rstn)
        expansion_mode && cyc.valid && !cyc.write && cyc.external && !st.width8_sync2
            |=> high_data_port_oe == 8'h00;
    endproperty
    a_read16_hiz: assert property (p_read16_hiz) else $error("High port driven on 16-bit read.");

    property p_write16_high;
        @(posedge clk_sys) disable iff (!rstn)
        expansion_mode && cyc.valid && cyc.write && !st.width8_sync2
            |=> high_data_port_out == $past(cyc.wdata[15:8]);
    endproperty
    a_write16_high: assert property (p_write16_high) else $error("16-bit write high lane wrong.");

    property p_int_write16;
        @(posedge clk_sys) disable iff (!rstn)
        expansion_mode && cyc.valid && cyc.write && !cyc.external && !st.width8_sync2
            |=> low_data_port_out == $past(cyc.wdata[7:0]);
    endproperty
    a_int_write16: assert property (p_int_write16) else $error("Internal write value not on pins.");

    property p_int_read8;
        @(posedge clk_sys) disable iff (!rstn)
        expansion_mode && cyc.valid && !cyc.write && !cyc.external && st.width8_sync2
            |=> low_data_port_oe == 8'h00;
    endproperty
    a_int_read8: assert property (p_int_read8) else $error("Low port driven on 8-bit internal read.");

    property p_read8_even;
        @(posedge clk_sys) disable iff (!rstn)
        expansion_mode && cyc.valid && !cyc.write && cyc.external && st.width8_sync2 && !cyc.muxed && !cyc.addr_odd
            |=> rvalid && rdata[7:0] == $past(st.low_sync2) && rdata[15:8] == $past(rdata[15:8]);
    endproperty
    a_read8_even: assert property (p_read8_even) else $error("8-bit even read lane wrong.");

    property p_write8_even;
        @(posedge clk_sys) disable iff (!rstn)
        expansion_mode && cyc.valid && cyc.write && st.width8_sync2 && !cyc.muxed && !cyc.addr_odd
            |=> low_data_port_out == $past(cyc.wdata[7:0]);
    endproperty
    a_write8_even: assert property (p_write8_even) else $error("8-bit even write lane wrong.");

    property p_muxed_data_rd;
        @(posedge clk_sys) disable iff (!rstn)
        expansion_mode && cyc.valid && !cyc.write && cyc.external && st.width8_sync2 && cyc.muxed && !cyc.strobe_n
            |=> rvalid && low_data_port_oe == 8'h00;
    endproperty
    a_muxed_data_rd: assert property (p_muxed_data_rd) else $error("Muxed read data phase wrong.");

    property p_muxed_data_wr;
        @(posedge clk_sys) disable iff (!rstn)
        expansion_mode && cyc.valid && cyc.write && st.width8_sync2 && cyc.muxed && !cyc.strobe_n && !cyc.addr_odd
            |=> low_data_port_out == $past(cyc.wdata[7:0]);
    endproperty
    a_muxed_data_wr: assert property (p_muxed_data_wr) else $error("Muxed write data phase wrong.");

    property p_muxed_addr_oe;
        @(posedge clk_sys) disable iff (!rstn)
        expansion_mode && cyc.valid && cyc.external && st.width8_sync2 && cyc.muxed && cyc.strobe_n
            |=> low_data_port_oe == 8'hFF;
    endproperty
    a_muxed_addr_oe: assert property (p_muxed_addr_oe) else $error("Muxed address not driven.");

    property p_high_gpio_out;
        @(posedge clk_sys) disable iff (!rstn)
        expansion_mode && st.width8_sync2
            |=> high_data_port_out == $past(gpio_high.out);
    endproperty
    a_high_gpio_out: assert property (p_high_gpio_out) else $error("High port value not from port logic.");

    property p_single_high;
        @(posedge clk_sys) disable iff (!rstn)
        !expansion_mode
            |=> high_data_port_oe == $past(gpio_high.oe) && high_data_port_out == $past(gpio_high.out);
    endproperty
    a_single_high: assert property (p_single_high) else $error("High port not plain I/O in single-chip mode.");

    property p_single_low_out;
        @(posedge clk_sys) disable iff (!rstn)
        !expansion_mode
            |=> low_data_port_out == $past(gpio_low.out);
    endproperty
    a_single_low_out: assert property (p_single_low_out) else $error("Low port value not from port logic.");

    property p_gpio_in;
        @(posedge clk_sys) disable iff (!rstn)
        1'b1
            |=> gpio_low_in == $past(st.low_sync2) && gpio_high_in == $past(st.high_sync2);
    endproperty
    a_gpio_in: assert property (p_gpio_in) else $error("Port input levels not passed on.");

    property p_rvalid_only_read;
        @(posedge clk_sys) disable iff (!rstn)
        !(expansion_mode && cyc.valid && !cyc.write && cyc.external)
            |=> !rvalid;
    endproperty
    a_rvalid_only_read: assert property (p_rvalid_only_read) else $error("Read strobe without external read.");

    property p_idle16_hiz;
        @(posedge clk_sys) disable iff (!rstn)
        expansion_mode && !cyc.valid && !st.width8_sync2
            |=> low_data_port_oe == 8'h00 && high_data_port_oe == 8'h00;
    endproperty
    a_idle16_hiz: assert property (p_idle16_hiz) else $error("Data pins driven while idle.");

endmodule : lane_steer

// *** testbench/ext_memory_model.sv ***
// External memory on the parallel data bus, resolving the two data ports.
`timescale 1ns/1ps
module ext_memory_model (
    input wire logic clk_sys,
    input wire logic drv_lo,
    input wire logic drv_hi,
    input wire logic [15:0] mem_data,
    input wire logic [7:0] lo_out,
    input wire logic [7:0] lo_oe,
    input wire logic [7:0] hi_out,
    input wire logic [7:0] hi_oe,
    output logic [7:0] lo_pin,
    output logic [7:0] hi_pin
);
    // ------------------------------------------------------------
    // Pin resolution
    // ------------------------------------------------------------
    logic [7:0] last_lo = 8'h00;
    logic [7:0] last_hi = 8'h00;
    // Released bits show the memory data when the memory drives, else the inverse of their last level each cycle.
    always_ff @(posedge clk_sys) begin
        last_lo <= lo_pin;
        last_hi <= hi_pin;
    end
    assign lo_pin = (lo_oe & lo_out) | (~lo_oe & (drv_lo ? mem_data[7:0] : ~last_lo));
    assign hi_pin = (hi_oe & hi_out) | (~hi_oe & (drv_hi ? mem_data[15:8] : ~last_hi));
endmodule : ext_memory_model

// *** testbench/external_data_bus_lane_steering_bench.sv ***
// Self-checking bench for the data lane steering block.
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; $display("Error %0t: got %h exp %h", $time, (g), (e)); end end
module external_data_bus_lane_steering_bench;
    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    logic clk_sys = 1'b0, rstn = 1'b0, expansion_mode = 1'b0, bus_width8_pin = 1'b0, rvalid, drv_lo = 1'b0, drv_hi = 1'b0;
    lane_steer_pkg::cycle_s cyc = '0;
    lane_steer_pkg::pin_drive_s gpio_low = '0, gpio_high = '0;
    logic [7:0] lo_in, hi_in, lo_out, lo_oe, hi_out, hi_oe, g_lo_in, g_hi_in;
    logic [15:0] rdata, mem_data = 16'h0000;
    int error_cnt = 0, cmp_count = 0, cycles = 0;
    always #25 clk_sys = ~clk_sys;
    lane_steer u_dut (.clk_sys(clk_sys), .rstn(rstn), .expansion_mode(expansion_mode), .bus_width8_pin(bus_width8_pin),
        .cyc(cyc), .gpio_low(gpio_low), .gpio_high(gpio_high), .low_data_port_in(lo_in), .high_data_port_in(hi_in),
        .low_data_port_out(lo_out), .low_data_port_oe(lo_oe), .high_data_port_out(hi_out), .high_data_port_oe(hi_oe),
        .rdata(rdata), .rvalid(rvalid), .gpio_low_in(g_lo_in), .gpio_high_in(g_hi_in));
    ext_memory_model u_mem (.clk_sys(clk_sys), .drv_lo(drv_lo), .drv_hi(drv_hi), .mem_data(mem_data), .lo_out(lo_out),
        .lo_oe(lo_oe), .hi_out(hi_out), .hi_oe(hi_oe), .lo_pin(lo_in), .hi_pin(hi_in));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick
    task do_reset(input logic w8);
        rstn = 1'b0;
        bus_width8_pin = w8;
        tick(3);
        rstn = 1'b1;
        tick(3);
    endtask : do_reset
    task access(input logic wr, input logic ext, input logic odd, input logic mx, input logic stb, input logic [15:0] wd);
        cyc = '{valid: 1'b1, write: wr, external: ext, muxed: mx, strobe_n: stb, addr_odd: odd, low_addr: 8'h7E, wdata: wd};
        tick(1);
        cyc.valid = 1'b0;
    endtask : access
    task pins(input logic [7:0] lo, input logic [7:0] loe, input logic [7:0] hi, input logic [7:0] hoe);
        `CHK(lo_oe, loe)
        `CHK(lo_out & loe, lo)
        `CHK(hi_oe, hoe)
        `CHK(hi_out & hoe, hi)
    endtask : pins
    task report_and_stop;
        $display("Counts: %0d compares, %0d errors", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : report_and_stop
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_single;
        gpio_low = '{out: 8'h96, oe: 8'hF0};
        gpio_high = '{out: 8'h3C, oe: 8'h0F};
        mem_data = 16'hA055;
        drv_lo = 1'b1;
        drv_hi = 1'b1;
        tick(6);
        pins(8'h90, 8'hF0, 8'h0C, 8'h0F);
        `CHK(g_lo_in, 8'h95)
        `CHK(g_hi_in, 8'hAC)
        $display("Test single-chip done");
    endtask : t_single
    task t_wide;
        do_reset(1'b0);
        expansion_mode = 1'b1;
        drv_lo = 1'b0;
        drv_hi = 1'b0;
        access(1, 1, 0, 0, 0, 16'hA55A);
        pins(8'h5A, 8'hFF, 8'hA5, 8'hFF);
        access(1, 0, 1, 0, 0, 16'h1234);
        pins(8'h34, 8'hFF, 8'h12, 8'hFF);
        mem_data = 16'hC33C;
        drv_lo = 1'b1;
        drv_hi = 1'b1;
        tick(3);
        access(0, 1, 1, 0, 0, 16'h0000);
        `CHK(rvalid, 1'b1)
        `CHK(rdata, 16'hC33C)
        pins(8'h00, 8'h00, 8'h00, 8'h00);
        mem_data = 16'h5AA5;
        tick(3);
        access(0, 1, 0, 0, 0, 16'h0000);
        `CHK(rdata, 16'hC3A5)
        pins(8'h00, 8'h00, 8'h00, 8'h00);
        access(0, 0, 1, 0, 0, 16'h0000);
        pins(8'h00, 8'h00, 8'h00, 8'h00);
        $display("Test 16-bit bus done");
    endtask : t_wide
    task t_narrow;
        drv_lo = 1'b0;
        drv_hi = 1'b0;
        do_reset(1'b1);
        gpio_high = '{out: 8'h81, oe: 8'hFF};
        access(1, 1, 0, 0, 0, 16'hBEEF);
        pins(8'hEF, 8'hFF, 8'h81, 8'hFF);
        access(1, 1, 1, 0, 0, 16'hBEEF);
        pins(8'hBE, 8'hFF, 8'h81, 8'hFF);
        access(1, 1, 0, 1, 1, 16'hBEEF);
        pins(8'h7E, 8'hFF, 8'h81, 8'hFF);
        access(1, 1, 0, 1, 0, 16'hBEEF);
        pins(8'hEF, 8'hFF, 8'h81, 8'hFF);
        mem_data = 16'h00A7;
        drv_lo = 1'b1;
        tick(3);
        access(0, 1, 0, 0, 0, 16'h0000);
        `CHK(rvalid, 1'b1)
        `CHK(rdata, 16'h00A7)
        access(0, 1, 1, 0, 0, 16'h0000);
        `CHK(rdata, 16'hA7A7)
        access(0, 1, 0, 1, 1, 16'h0000);
        `CHK(rvalid, 1'b0)
        pins(8'h7E, 8'hFF, 8'h81, 8'hFF);
        access(0, 1, 0, 1, 0, 16'h0000);
        `CHK(rvalid, 1'b1)
        `CHK(rdata, 16'hA7A7)
        `CHK(lo_oe, 8'h00)
        $display("Test 8-bit bus done");
    endtask : t_narrow
    // ------------------------------------------------------------
    // Main sequence and timeout
    // ------------------------------------------------------------
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 1000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    initial begin
        do_reset(1'b0);
        t_single();
        t_wide();
        t_narrow();
        report_and_stop();
    end
endmodule : external_data_bus_lane_steering_bench
